// >>> microport_device.sv
// Purpose: device end: external registers reaching an internal register space
// Assumes: pins synchronous to ref_clk_in, one access at a time
// Notes: internal bus is a two-cycle strobe/response port on the user side
`timescale 1ns/1ps
`default_nettype none
module microport_device
   import microport_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Pins
   microport_if.device port,
   // Strap: strobe style
   input wire logic mode_in,
   // Internal register space
   output logic [11:0] int_addr_out,
   output logic [31:0] int_wdata_out,
   output logic int_wr_out,
   output logic int_rd_out,
   input wire logic [31:0] int_rdata_in,
   // Channel control
   output logic [3:0] sleep_out,
   output logic [3:0] prog_enable_out,
   output logic [3:0] beam_sync_out,
   output logic [3:0] hop_sync_out,
   output logic [3:0] start_sync_out,
   input wire logic [3:0] pin_start_sync_in
);
   logic active, is_write, active_q, start;
   logic [7:0] byte_reg [4];
   logic [7:0] sleep_reg, low_addr_reg, high_addr_reg;
   logic [1:0] cnt_reg;
   logic busy_reg, acc_read0_reg, acc_write0_reg;
   logic ack_pull_reg;
   logic [7:0] data_out_reg;
   logic data_oe_reg;
   logic complete;
   logic [11:0] int_addr;
   logic [11:0] int_addr_next;
   logic [31:0] wword;
   logic mem_target;

   ////////////////////////////////////////////////////////////////////////////
   // Strobe decode
   // [R13] mode strap selects
   always_comb begin
      if (mode_in == STROBE_DIRECTION_MODE) begin
         active = ~port.cs_n & ~port.strobe_n;
         is_write = ~port.wr_dir;
      end else begin
         active = ~port.cs_n & (~port.strobe_n | ~port.wr_dir);
         is_write = ~port.wr_dir;
      end
   end

   // [R17] new access per strobe
   assign start = active & ~active_q;
   assign complete = busy_reg & (cnt_reg == REG_ACCESS_CYCLES);

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         active_q <= 1'b0;
      end else begin
         active_q <= active;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address registers
   // [R1] twelve-bit address
   assign int_addr = {high_addr_reg[3:0], low_addr_reg};
   assign int_addr_next = int_addr + 12'h001;
   assign wword = {byte_reg[3], byte_reg[2], byte_reg[1], port.bus_data};
   // [R10] channel memory gate
   assign mem_target = (int_addr[11:8] >= 4'h1) && (int_addr[11:8] <= 4'h4) && (low_addr_reg >= MEM_REGION_LO)
      && !prog_enable_out[2'(int_addr[11:8] - 4'h1)];

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         low_addr_reg <= RESET_BYTE;
         high_addr_reg <= RESET_BYTE;
      end else if (start && is_write && port.addr == OFS_LOW_ADDR) begin
         low_addr_reg <= port.bus_data;
      end else if (start && is_write && port.addr == OFS_HIGH_ADDR) begin
         high_addr_reg <= port.bus_data;
      // [R22] increment after completion
      end else if (complete && ((acc_read0_reg && high_addr_reg[BIT_RD_INC])
                  || (acc_write0_reg && high_addr_reg[BIT_WR_INC]))) begin
         // [R2] auto increment
         low_addr_reg <= int_addr_next[7:0];
         high_addr_reg <= {high_addr_reg[7:4], int_addr_next[11:8]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data bytes
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < 4; i++) begin
            byte_reg[i] <= RESET_BYTE;
         end
      end else if (complete && acc_read0_reg) begin
         // [R5] whole word copied
         for (int i = 0; i < 4; i++) begin
            byte_reg[i] <= int_rdata_in[8*i +: 8];
         end
      end else if (start && is_write && !port.addr[2]) begin
         // [R23] held until written
         byte_reg[port.addr[1:0]] <= port.bus_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Access timing
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         busy_reg <= 1'b0;
         cnt_reg <= 2'h0;
         acc_read0_reg <= 1'b0;
         acc_write0_reg <= 1'b0;
      end else if (start) begin
         busy_reg <= 1'b1;
         // [R7] two cycles internal
         cnt_reg <= (port.addr == OFS_DATA_BYTE_LOWEST) ? INT_ACCESS_CYCLES : REG_ACCESS_CYCLES;
         acc_read0_reg <= !is_write && port.addr == OFS_DATA_BYTE_LOWEST;
         acc_write0_reg <= is_write && port.addr == OFS_DATA_BYTE_LOWEST;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - 2'h1;
         if (complete) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // [R4] write launched by byte zero
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         int_wr_out <= 1'b0;
         int_rd_out <= 1'b0;
         int_addr_out <= 12'h000;
         int_wdata_out <= 32'h0000_0000;
      end else begin
         int_wr_out <= start && is_write && port.addr == OFS_DATA_BYTE_LOWEST && !mem_target;
         int_rd_out <= start && !is_write && port.addr == OFS_DATA_BYTE_LOWEST;
         if (start) begin
            int_addr_out <= int_addr;
            // [R3] byte zero least significant
            int_wdata_out <= wword;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ready / acknowledge
   // [R16] only pulls low
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ack_pull_reg <= 1'b0;
      end else if (mode_in == STROBE_PAIR_MODE) begin
         // [R14] low from start to completion
         if (start) begin
            ack_pull_reg <= 1'b1;
         end else if (complete) begin
            ack_pull_reg <= 1'b0;
         end
      end else begin
         // [R15] low until strobe removed
         if (complete) begin
            ack_pull_reg <= 1'b1;
         end else if (!active && !busy_reg) begin
            ack_pull_reg <= 1'b0;
         end
      end
   end
   assign port.dev_ack_oe = ack_pull_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Read data
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         data_out_reg <= RESET_BYTE;
         data_oe_reg <= 1'b0;
      end else begin
         // [R20] eight-bit two-way bus
         data_oe_reg <= active && !is_write;
         if (complete && acc_read0_reg) begin
            data_out_reg <= int_rdata_in[7:0];
         end else begin
            case (port.addr)
               OFS_DATA_BYTE_LOWEST, OFS_DATA_BYTE_SECOND, OFS_DATA_BYTE_THIRD, OFS_DATA_BYTE_HIGHEST: data_out_reg <= byte_reg[port.addr[1:0]];
               OFS_SLEEP: data_out_reg <= sleep_reg;
               OFS_LOW_ADDR: data_out_reg <= low_addr_reg;
               OFS_HIGH_ADDR: data_out_reg <= high_addr_reg;
               // [R9] write only, reads zero
               default: data_out_reg <= 8'h00;
            endcase
         end
      end
   end
   assign port.dev_data = data_out_reg;
   assign port.dev_data_oe = data_oe_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Sleep and sync
   logic sync_wr;
   assign sync_wr = start && is_write && port.addr == OFS_SYNC;

   // [R8] immediate effect
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         beam_sync_out <= 4'h0;
         hop_sync_out <= 4'h0;
         start_sync_out <= 4'h0;
      end else begin
         // [R9] per-channel sync pulses
         beam_sync_out <= (sync_wr && port.bus_data[BIT_BEAM]) ? port.bus_data[3:0] : 4'h0;
         hop_sync_out <= (sync_wr && port.bus_data[BIT_HOP]) ? port.bus_data[3:0] : 4'h0;
         start_sync_out <= ((sync_wr && port.bus_data[BIT_START]) ? port.bus_data[3:0] : 4'h0)
            | pin_start_sync_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sleep_reg <= RESET_BYTE;
      end else if (start && is_write && port.addr == OFS_SLEEP) begin
         // [R11] direct bring-up
         sleep_reg <= port.bus_data;
      end else begin
         // [R12] start sync clears sleep
         sleep_reg[3:0] <= sleep_reg[3:0] & ~start_sync_out;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sleep_out <= 4'h0;
         prog_enable_out <= 4'h0;
      end else begin
         sleep_out <= sleep_reg[3:0];
         // [R10] program enables
         prog_enable_out <= sleep_reg[7:4];
      end
   end
endmodule
`default_nettype wire

// >>> microport_pkg.sv
// Purpose: constants shared by both ends of the indirect host microport
// Assumes: one 250 MHz clock at both ends, synchronous active-high reset
// Notes: offsets are the 3-bit external register selects
//
// Overview of operation
// [R1] Internal address twelve bits, data thirty-two
// [R2] Upper address bit6 read increment, bit7 write
// [R3] Bytes zero to three form word, LSB first
// [R4] Writing byte zero launches internal write
// [R5] Reading byte zero launches internal read
// [R6] Host reads byte zero before others
// [R7] Each internal access takes two cycles
// [R8] Sleep and sync writes act at once
// [R9] Sync register write only, per channel
// [R10] Memory loading needs channel program enable
// [R11] Sleep bits D3..D0 activate channels D..A
// [R12] Start sync clears addressed sleep bits
// [R13] Mode input picks strobe style
// [R14] Pair mode: ready low until completion
// [R15] Direction mode: ack low until strobe removed
// [R16] Ready/ack pin is open drain
// [R17] Back-to-back accesses under held select
// [R18] Host loads both address registers first
// [R19] Sixteen-bit location: byte one, then zero
// [R20] Three-bit select, eight-bit two-way data
// [R21] Host writes sync bits low when unused
// [R22] Increment only after access completes
// [R23] Data bytes hold until overwritten
package microport_pkg;
   localparam logic [2:0] OFS_DATA_BYTE_LOWEST = 3'h0;
   localparam logic [2:0] OFS_DATA_BYTE_SECOND = 3'h1;
   localparam logic [2:0] OFS_DATA_BYTE_THIRD = 3'h2;
   localparam logic [2:0] OFS_DATA_BYTE_HIGHEST = 3'h3;
   localparam logic [2:0] OFS_SLEEP = 3'h4;
   localparam logic [2:0] OFS_SYNC = 3'h5;
   localparam logic [2:0] OFS_LOW_ADDR = 3'h6;
   localparam logic [2:0] OFS_HIGH_ADDR = 3'h7;
   localparam int BIT_RD_INC = 6;
   localparam int BIT_WR_INC = 7;
   localparam int BIT_BEAM = 6;
   localparam int BIT_HOP = 5;
   localparam int BIT_START = 4;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] INT_ACCESS_CYCLES = 2'h2;
   localparam logic [1:0] REG_ACCESS_CYCLES = 2'h1;
   localparam logic [1:0] HOST_SETTLE_CYCLES = 2'h2;
   // Offsets at or above this within a channel page hold coefficient/data memory
   localparam logic [7:0] MEM_REGION_LO = 8'h80;
   localparam logic STROBE_PAIR_MODE = 1'b0;
   localparam logic STROBE_DIRECTION_MODE = 1'b1;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SETUP = 2'b01,
      H_STROBE = 2'b10,
      H_RELEASE = 2'b11
   } host_state_t;
endpackage

// >>> microport_if.sv
// Purpose: pins between host and device microport ends
// Assumes: one host, pull-up on the ready/acknowledge line
// Notes: two-way and open-drain wires are resolved here from the enables
`timescale 1ns/1ps
`default_nettype none
interface microport_if;
   logic cs_n;
   logic strobe_n;
   logic wr_dir;
   logic [2:0] addr;
   logic [7:0] host_data;
   logic host_data_oe;
   logic [7:0] dev_data;
   logic dev_data_oe;
   logic dev_ack_oe;
   logic [7:0] bus_data;
   logic transfer_acknowledge_n;
   // Undriven bus floats high as with a weak pull-up
   assign bus_data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);
   assign transfer_acknowledge_n = ~dev_ack_oe;
   modport device (input cs_n, strobe_n, wr_dir, addr, bus_data,
                   output dev_data, dev_data_oe, dev_ack_oe);
   modport host (input bus_data, transfer_acknowledge_n,
                 output cs_n, strobe_n, wr_dir, addr, host_data, host_data_oe);
endinterface
`default_nettype wire

// >>> microport_host.sv
// Purpose: host end: turns single register commands into microport pin cycles
// Assumes: clocked by the device clock, one device on the line
// Notes: ordering of data byte accesses is the user's duty
`timescale 1ns/1ps
`default_nettype none
module microport_host
   import microport_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Strobe style, matching the device strap
   input wire logic mode_in,
   // Command port
   input wire logic cmd_valid_in,
   input wire logic cmd_write_in,
   input wire logic [2:0] cmd_addr_in,
   input wire logic [7:0] cmd_data_in,
   output logic cmd_ready_out,
   output logic rsp_valid_out,
   output logic [7:0] rsp_data_out,
   // Pins
   microport_if.host port
);
   host_state_t state_reg;
   logic [1:0] wait_reg;
   logic write_reg;
   logic cs_n_reg, strobe_n_reg, wr_dir_reg, data_oe_reg;
   logic [2:0] addr_reg;
   logic [7:0] data_reg;
   logic ack_seen;

   // [R14] ready high ends pair access
   // [R15] ack low ends direction access
   assign ack_seen = (mode_in == STROBE_PAIR_MODE) ? port.transfer_acknowledge_n : ~port.transfer_acknowledge_n;

   ////////////////////////////////////////////////////////////////////////////
   // Access sequence
   // [R6] [R18] [R19] [R21] command order is the user's
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_reg <= H_IDLE;
         wait_reg <= 2'h0;
         write_reg <= 1'b0;
         cmd_ready_out <= 1'b0;
         rsp_valid_out <= 1'b0;
         rsp_data_out <= 8'h00;
         cs_n_reg <= 1'b1;
         strobe_n_reg <= 1'b1;
         wr_dir_reg <= 1'b1;
         data_oe_reg <= 1'b0;
         addr_reg <= 3'h0;
         data_reg <= 8'h00;
      end else begin
         rsp_valid_out <= 1'b0;
         case (state_reg)
            H_IDLE: begin
               cmd_ready_out <= 1'b1;
               if (cmd_valid_in && cmd_ready_out) begin
                  cmd_ready_out <= 1'b0;
                  write_reg <= cmd_write_in;
                  addr_reg <= cmd_addr_in;
                  data_reg <= cmd_data_in;
                  data_oe_reg <= cmd_write_in;
                  cs_n_reg <= 1'b0;
                  // Direction set up before the strobe in direction mode
                  wr_dir_reg <= (mode_in == STROBE_DIRECTION_MODE) ? !cmd_write_in : 1'b1;
                  state_reg <= H_SETUP;
               end
            end
            H_SETUP: begin
               // [R17] one strobe per access
               if (mode_in == STROBE_DIRECTION_MODE || !write_reg) begin
                  strobe_n_reg <= 1'b0;
               end else begin
                  wr_dir_reg <= 1'b0;
               end
               wait_reg <= HOST_SETTLE_CYCLES;
               state_reg <= H_STROBE;
            end
            H_STROBE: begin
               if (wait_reg != 2'h0) begin
                  wait_reg <= wait_reg - 2'h1;
               end else if (ack_seen) begin
                  rsp_data_out <= port.bus_data;
                  rsp_valid_out <= !write_reg;
                  strobe_n_reg <= 1'b1;
                  wr_dir_reg <= 1'b1;
                  state_reg <= H_RELEASE;
               end
            end
            H_RELEASE: begin
               data_oe_reg <= 1'b0;
               if (port.transfer_acknowledge_n) begin
                  cs_n_reg <= 1'b1;
                  state_reg <= H_IDLE;
               end
            end
            default: state_reg <= H_IDLE;
         endcase
      end
   end

   assign port.cs_n = cs_n_reg;
   assign port.strobe_n = strobe_n_reg;
   assign port.wr_dir = wr_dir_reg;
   assign port.addr = addr_reg;
   assign port.host_data = data_reg;
   assign port.host_data_oe = data_oe_reg;
endmodule
`default_nettype wire

// >>> microport_chk.sv
// Purpose: pin-level timing checks of the microport device end
// Assumes: signals of microport_if plus the strap, one clock domain
// Notes: an access starts on the first cycle it is seen active
`timescale 1ns/1ps
`default_nettype none
module microport_chk
   import microport_pkg::*;
(
   // Clock, reset and strap
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic mode_in,
   // Pins
   input wire logic cs_n,
   input wire logic strobe_n,
   input wire logic wr_dir,
   input wire logic [2:0] addr,
   input wire logic dev_data_oe,
   input wire logic dev_ack_oe
);
   logic act;
   logic act_reg;
   logic start;
   logic is_rd;
   assign act = !cs_n && (mode_in ? !strobe_n : (!strobe_n || !wr_dir));
   assign is_rd = mode_in ? wr_dir : !strobe_n;
   assign start = act && !act_reg;
   always_ff @(posedge ref_clk_in) begin
      act_reg <= rst_in ? 1'b0 : act;
   end
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);
   ////////////////////////////////////////////////////////////////////////////
   chk_pair_ready_low: assert property (!mode_in && start |=> dev_ack_oe)
      else $error("ready not pulled at access start");
   chk_pair_word_time: assert property (!mode_in && start && addr == OFS_DATA_BYTE_LOWEST |=> dev_ack_oe [*2] ##1 !dev_ack_oe)
      else $error("ready not released two cycles after word access");
   chk_pair_reg_time: assert property (!mode_in && start && addr != OFS_DATA_BYTE_LOWEST |=> dev_ack_oe ##1 !dev_ack_oe)
      else $error("ready not released after register access");
   chk_dir_ack_late: assert property (mode_in && start && addr == OFS_DATA_BYTE_LOWEST |=> !dev_ack_oe [*2] ##1 dev_ack_oe)
      else $error("acknowledge not given when word access completes");
   chk_dir_ack_hold: assert property (mode_in && dev_ack_oe && !strobe_n |=> dev_ack_oe)
      else $error("acknowledge dropped while strobe still low");
   chk_dir_ack_drop: assert property (mode_in && dev_ack_oe && strobe_n |-> ##[1:2] !dev_ack_oe)
      else $error("acknowledge held after strobe removed");
   chk_read_drive: assert property (start && is_rd |=> dev_data_oe)
      else $error("data bus not driven on read");
   chk_idle_release: assert property (cs_n [*3] |-> !dev_ack_oe && !dev_data_oe)
      else $error("pins driven while deselected");
endmodule
`default_nettype wire

// >>> testbench.sv
// Purpose: both microport ends joined, driven from the host command port
// Assumes: 250 MHz clock, internal space modelled as a word array
// Notes: the whole sequence runs once in each strobe style
`timescale 1ns/1ps
`default_nettype none
module testbench
   import microport_pkg::*;
;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic mode_in = 1'b0;
   logic cmd_valid_in = 1'b0;
   logic cmd_write_in = 1'b0;
   logic [2:0] cmd_addr_in = 3'h0;
   logic [7:0] cmd_data_in = 8'h00;
   logic cmd_ready_out;
   logic rsp_valid_out;
   logic [7:0] rsp_data_out;
   logic [11:0] int_addr_out;
   logic [31:0] int_wdata_out;
   logic int_wr_out;
   logic int_rd_out;
   logic [31:0] int_rdata_in = 32'h0;
   logic [3:0] sleep_out;
   logic [3:0] prog_enable_out;
   logic [3:0] beam_sync_out;
   logic [3:0] hop_sync_out;
   logic [3:0] start_sync_out;
   logic [3:0] pin_start_sync_in = 4'h0;
   logic [31:0] mem [0:4095];
   logic [11:0] seen = 12'h000;
   logic seen_clr = 1'b0;
   logic [7:0] rd_byte;
   logic [7:0] k;
   int wr_count = 0;
   int n0;
   int num_errors = 0;
   int n_compared = 0;
   always #2 ref_clk_in = ~ref_clk_in;
   ////////////////////////////////////////////////////////////////////////////
   microport_if port_bus ();
   microport_host u_microport_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .mode_in(mode_in),
      .cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in), .cmd_addr_in(cmd_addr_in),
      .cmd_data_in(cmd_data_in), .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
      .rsp_data_out(rsp_data_out), .port(port_bus.host));
   microport_device u_microport_device (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .port(port_bus.device),
      .mode_in(mode_in), .int_addr_out(int_addr_out), .int_wdata_out(int_wdata_out), .int_wr_out(int_wr_out),
      .int_rd_out(int_rd_out), .int_rdata_in(int_rdata_in), .sleep_out(sleep_out),
      .prog_enable_out(prog_enable_out), .beam_sync_out(beam_sync_out), .hop_sync_out(hop_sync_out),
      .start_sync_out(start_sync_out), .pin_start_sync_in(pin_start_sync_in));
   microport_chk u_microport_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .mode_in(mode_in),
      .cs_n(port_bus.cs_n), .strobe_n(port_bus.strobe_n), .wr_dir(port_bus.wr_dir), .addr(port_bus.addr),
      .dev_data_oe(port_bus.dev_data_oe), .dev_ack_oe(port_bus.dev_ack_oe));
   ////////////////////////////////////////////////////////////////////////////
   // Read data toggles outside reads so a late sample cannot pass by luck
   always @(posedge ref_clk_in) begin
      if (int_wr_out) begin
         mem[int_addr_out] <= int_wdata_out;
         wr_count <= wr_count + 1;
      end
      int_rdata_in <= int_rd_out ? mem[int_addr_out] : ~int_rdata_in;
      seen <= seen_clr ? 12'h000 : (seen | {beam_sync_out, hop_sync_out, start_sync_out});
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask
   task automatic final_report();
      if (num_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic tick(inout int n);
      @(posedge ref_clk_in);
      #1;
      n++;
      if (n > 200) begin
         num_errors++;
         final_report();
      end
   endtask
   task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d);
      int n;
      logic got;
      n = 0;
      got = 1'b0;
      while (cmd_ready_out !== 1'b1) begin
         tick(n);
      end
      @(posedge ref_clk_in);
      cmd_valid_in <= 1'b1;
      cmd_write_in <= wr;
      cmd_addr_in <= a;
      cmd_data_in <= d;
      @(posedge ref_clk_in);
      cmd_valid_in <= 1'b0;
      #1;
      n = 0;
      // Wait out the whole pin cycle so internal side effects have landed before any check
      while (cmd_ready_out !== 1'b1) begin
         if (rsp_valid_out === 1'b1) begin
            got = 1'b1;
            rd_byte = rsp_data_out;
         end
         tick(n);
      end
      check("response pulse", !wr, got);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      access(1'b1, a, d);
   endtask
   task automatic rd(input logic [2:0] a);
      access(1'b0, a, 8'h00);
   endtask
   task automatic clear_seen();
      seen_clr <= 1'b1;
      @(posedge ref_clk_in);
      seen_clr <= 1'b0;
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int m = 0; m < 2; m++) begin
         @(posedge ref_clk_in);
         rst_in <= 1'b1;
         mode_in <= m[0];
         repeat (20) @(posedge ref_clk_in);
         rst_in <= 1'b0;
         #1;
         k = m[0] ? 8'h40 : 8'h00;
         wr(OFS_HIGH_ADDR, 8'h81);
         wr(OFS_LOW_ADDR, 8'h10);
         wr(OFS_DATA_BYTE_HIGHEST, 8'h44 + k);
         wr(OFS_DATA_BYTE_THIRD, 8'h33 + k);
         wr(OFS_DATA_BYTE_SECOND, 8'h22 + k);
         wr(OFS_DATA_BYTE_LOWEST, 8'h11 + k);
         check("word 110", {8'h44 + k, 8'h33 + k, 8'h22 + k, 8'h11 + k}, mem[12'h110]);
         wr(OFS_DATA_BYTE_SECOND, 8'h66 + k);
         wr(OFS_DATA_BYTE_LOWEST, 8'h55 + k);
         check("word 111", {8'h44 + k, 8'h33 + k, 8'h66 + k, 8'h55 + k}, mem[12'h111]);
         wr(OFS_DATA_BYTE_HIGHEST, 8'hee);
         wr(OFS_HIGH_ADDR, 8'h41);
         wr(OFS_LOW_ADDR, 8'h10);
         rd(OFS_DATA_BYTE_HIGHEST);
         check("stale data_byte_highest", 8'hee, rd_byte);
         rd(OFS_DATA_BYTE_LOWEST);
         check("data_byte_lowest", 8'h11 + k, rd_byte);
         rd(OFS_DATA_BYTE_HIGHEST);
         check("data_byte_highest", 8'h44 + k, rd_byte);
         rd(OFS_DATA_BYTE_SECOND);
         check("data_byte_second", 8'h22 + k, rd_byte);
         rd(OFS_DATA_BYTE_LOWEST);
         check("next data_byte_lowest", 8'h55 + k, rd_byte);
         rd(OFS_LOW_ADDR);
         check("low address", 8'h12, rd_byte);
         rd(OFS_HIGH_ADDR);
         check("high address", 8'h41, rd_byte);
         wr(OFS_SLEEP, 8'h0f);
         check("sleep on", 8'h0f, {prog_enable_out, sleep_out});
         clear_seen();
         wr(OFS_SYNC, 8'h1a);
         check("start pulses", 12'h00a, seen);
         check("sleep after start", 4'h5, sleep_out);
         clear_seen();
         wr(OFS_SYNC, 8'h6f);
         check("beam hop pulses", 12'hff0, seen);
         clear_seen();
         wr(OFS_SYNC, 8'h00);
         check("no sync pulses", 12'h000, seen);
         rd(OFS_SYNC);
         check("sync readback", 8'h00, rd_byte);
         @(posedge ref_clk_in);
         pin_start_sync_in <= 4'h1;
         @(posedge ref_clk_in);
         pin_start_sync_in <= 4'h0;
         repeat (3) @(posedge ref_clk_in);
         #1;
         rd(OFS_SLEEP);
         check("sleep after pin", 8'h04, rd_byte);
         wr(OFS_LOW_ADDR, 8'h80);
         wr(OFS_HIGH_ADDR, 8'h81);
         n0 = wr_count;
         wr(OFS_DATA_BYTE_LOWEST, 8'h77 + k);
         check("gated write", n0, wr_count);
         wr(OFS_SLEEP, 8'h14);
         check("prog enable", 4'h1, prog_enable_out);
         wr(OFS_DATA_BYTE_LOWEST, 8'h99 + k);
         check("enabled write", 8'h99 + k, mem[12'h181][7:0]);
      end
      final_report();
   end
endmodule
`default_nettype wire
